// ===== verilog/tpdmc_defines.vh
// Constants for the port data mux control block.
// Assumes inclusion by the block and its bench.
`ifndef TPDMC_DEFINES_VH
`define TPDMC_DEFINES_VH
// Register byte offsets
`define TPDMC_ROUTE_OFS  8'h00
`define TPDMC_DIR_OFS    8'h04
`define TPDMC_PSRC_OFS   8'h08
`define TPDMC_CSRC_OFS   8'h0c
`define TPDMC_PULL_OFS   8'h10
`define TPDMC_MON_OFS    8'h14
`define TPDMC_EVENT_OFS  8'h18
`define TPDMC_STAT_OFS   8'h1c
// Route fields
`define TPDMC_TOP_LSB    0
`define TPDMC_BOT_LSB    4
`define TPDMC_SBU_LSB    8
`define TPDMC_LSXANA_BIT 12
`define TPDMC_UARTHZ_BIT 13
`define TPDMC_LSXHZ_BIT  14
// Route selection codes
`define TPDMC_SEL_NONE   3'h0
`define TPDMC_SEL_ROOT   3'h1
`define TPDMC_SEL_EP     3'h2
`define TPDMC_SEL_SWD    3'h3
`define TPDMC_SEL_DBG12  3'h4
`define TPDMC_SEL_DBG34  3'h5
`define TPDMC_SEL_AUX    3'h6
`define TPDMC_SEL_CORE   3'h7
`define TPDMC_SEL_LSX    3'h2
// Pin source codes 0..2 are port channels
`define TPDMC_SRC_BYPASS 3'h3
// Reset values
`define TPDMC_ROUTE_RST  15'h0000
`define TPDMC_DIR_RST    6'h02
`define TPDMC_PSRC_RST   18'h00018
`define TPDMC_CSRC_RST   9'h000
// Responses
`define TPDMC_RESP_OKAY  2'h0
`define TPDMC_RESP_SLV   2'h2
`endif

// ===== verilog/tpdmc_port_mux.v
// Type-C port data multiplexer control with an AXI4-Lite register slave.
// Assumes mclk 50 MHz, synchronous active-low reset, pins asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "tpdmc_defines.vh"

module tpdmc_port_mux #(
  parameter NPIN = 6
) (
  input  wire        mclk,
  input  wire        rst_b,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        cableFlipped,
  input  wire [5:0]  portIn,
  output reg  [5:0]  portOut,
  output reg  [5:0]  portOe_b,
  input  wire [5:0]  sysPinIn,
  output reg  [5:0]  sysPinOut,
  output reg  [5:0]  sysPinOe_b,
  output reg  [2:0]  topSwitchSel,
  output reg  [2:0]  bottomSwitchSel,
  output reg  [2:0]  sbuSwitchSel,
  output reg         sbuSwap,
  output reg         lsxAnalogPass,
  output reg  [5:0]  pullUpEn,
  output reg  [5:0]  pullDownEn,
  output reg  [5:0]  compConnect,
  output reg         coreEvent
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Exchange top/bottom pairs and sideband pins on a flip
  function [5:0] flipPorts;
    input [5:0] v;
    input       f;
    begin
      flipPorts = f ? {v[4], v[5], v[1], v[0], v[3], v[2]} : v;
    end
  endfunction

  // Byte-lane merge of a write
  function [31:0] laneMerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer i;
    begin
      laneMerge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          laneMerge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers and state

  reg  [14:0] routeReg;
  reg  [5:0]  pinDir;
  reg  [17:0] pinSrc;
  reg  [8:0]  chanSrc;
  reg  [5:0]  pullUpReg;
  reg  [5:0]  pullDownReg;
  reg  [5:0]  monEn;
  reg  [5:0]  eventFlag;
  reg  [7:0]  wrAddr;
  reg  [31:0] wrData;
  reg  [3:0]  wrStrb;
  reg  [5:0]  portMeta;
  reg  [5:0]  portSync;
  reg  [5:0]  portPrev;
  reg  [5:0]  sysMeta;
  reg  [5:0]  sysSync;
  reg         flipMeta;
  reg         flipSync;

  wire [2:0] topSel  = routeReg[`TPDMC_TOP_LSB +: 3];
  wire [2:0] botSel  = routeReg[`TPDMC_BOT_LSB +: 3];
  wire [2:0] sbuSel  = routeReg[`TPDMC_SBU_LSB +: 3];
  wire       lsxAna  = routeReg[`TPDMC_LSXANA_BIT];
  wire       uartHz  = routeReg[`TPDMC_UARTHZ_BIT];
  wire       lsxHz   = routeReg[`TPDMC_LSXHZ_BIT];
  wire       doWrite = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire       wrHit   = (wrAddr[7:5] == 3'h0) && (wrAddr[1:0] == 2'h0);
  wire [5:0] edgeSeen = (portSync ^ portPrev) & monEn;
  wire [31:0] routeMerge = laneMerge({17'h0, routeReg}, wrData, wrStrb);
  wire [31:0] dirMerge   = laneMerge({26'h0, pinDir}, wrData, wrStrb);
  wire [31:0] psrcMerge  = laneMerge({14'h0, pinSrc}, wrData, wrStrb);
  wire [31:0] csrcMerge  = laneMerge({23'h0, chanSrc}, wrData, wrStrb);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  // Two flops on every asynchronous input
  always @(posedge mclk) begin
    portMeta <= portIn;
    portSync <= portMeta;
    portPrev <= portSync;
    sysMeta  <= sysPinIn;
    sysSync  <= sysMeta;
    flipMeta <= cableFlipped;
    flipSync <= flipMeta;
  end

  ////////////////////////////////////////////////////////////////////////
  // Routing and crossbar

  reg [5:0] logIn;
  reg [5:0] logOut;
  reg [5:0] logDrv;
  reg [2:0] chanRx;
  reg [2:0] chanTx;
  reg       sbuLsxDig;
  reg [5:0] next_sysOut;
  reg [5:0] next_sysOe_b;
  reg [2:0] sbuValid;
  integer   k;

  // Logical connector view, then back to physical pins
  always @* begin
    logIn = flipPorts(portSync, flipSync);
    sbuValid = (sbuSel == `TPDMC_SEL_ROOT) ? `TPDMC_SEL_NONE : sbuSel;
    sbuLsxDig = (sbuValid == `TPDMC_SEL_LSX) && !lsxAna;
    for (k = 0; k < 3; k = k + 1) begin
      chanTx[k] = sysSync[chanSrc[k*3 +: 3]];
    end
    chanRx[0] = (topSel == `TPDMC_SEL_CORE) ? logIn[1] : 1'b1;
    chanRx[1] = (botSel == `TPDMC_SEL_CORE) ? logIn[3] : 1'b1;
    chanRx[2] = (sbuValid == `TPDMC_SEL_CORE) ? logIn[5] : 1'b1;
    // Transmit on positive/first pins, receive on negative/second pins
    logOut = 6'h3f;
    logDrv = 6'h00;
    if (topSel == `TPDMC_SEL_CORE) begin
      logOut[0] = chanTx[0];
      logDrv[0] = !uartHz;
    end
    if (botSel == `TPDMC_SEL_CORE) begin
      logOut[2] = chanTx[1];
      logDrv[2] = !uartHz;
    end
    if (sbuValid == `TPDMC_SEL_CORE) begin
      logOut[4] = chanTx[2];
      logDrv[4] = !uartHz;
    end else if (sbuLsxDig) begin
      logOut[4] = sysSync[3];
      logDrv[4] = !lsxHz;
    end
    // Crossbar pins, direction and source per pin
    for (k = 0; k < NPIN; k = k + 1) begin
      case (pinSrc[k*3 +: 3])
        3'h0: next_sysOut[k] = chanRx[0];
        3'h1: next_sysOut[k] = chanRx[1];
        3'h2: next_sysOut[k] = chanRx[2];
        `TPDMC_SRC_BYPASS: next_sysOut[k] = sysSync[0];
        default: next_sysOut[k] = 1'b1;
      endcase
      next_sysOe_b[k] = !pinDir[k];
    end
    // Sideband serial pair bound to system pins 2 and 3
    if (sbuLsxDig) begin
      next_sysOut[2]  = logIn[5];
      next_sysOe_b[2] = 1'b0;
      next_sysOe_b[3] = 1'b1;
    end
    if (uartHz) begin
      next_sysOe_b[1:0] = 2'h3;
    end
    if (lsxHz) begin
      next_sysOe_b[3:2] = 2'h3;
    end
  end

  // Registered drive of every pin and switch
  always @(posedge mclk) begin
    if (!rst_b) begin
      portOut         <= 6'h3f;
      portOe_b        <= 6'h3f;
      sysPinOut       <= 6'h3f;
      sysPinOe_b      <= 6'h3f;
      topSwitchSel    <= `TPDMC_SEL_NONE;
      bottomSwitchSel <= `TPDMC_SEL_NONE;
      sbuSwitchSel    <= `TPDMC_SEL_NONE;
      sbuSwap         <= 1'b0;
      lsxAnalogPass   <= 1'b0;
      pullUpEn        <= 6'h00;
      pullDownEn      <= 6'h00;
      compConnect     <= 6'h00;
      coreEvent       <= 1'b0;
    end else begin
      portOut         <= flipPorts(logOut, flipSync);
      portOe_b        <= ~flipPorts(logDrv, flipSync);
      sysPinOut       <= next_sysOut;
      sysPinOe_b      <= next_sysOe_b;
      topSwitchSel    <= flipSync ? botSel : topSel;
      bottomSwitchSel <= flipSync ? topSel : botSel;
      sbuSwitchSel    <= sbuValid;
      sbuSwap         <= flipSync;
      lsxAnalogPass   <= (sbuValid == `TPDMC_SEL_LSX) && lsxAna;
      pullUpEn        <= pullUpReg;
      pullDownEn      <= pullDownReg;
      compConnect     <= monEn;
      coreEvent       <= |eventFlag;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file and AXI4-Lite slave

  reg [31:0] rdWord;
  reg        rdHit;
  // Read decode
  always @* begin
    rdWord = 32'h0;
    rdHit  = s_axi_araddr[1:0] == 2'h0;
    case (s_axi_araddr)
      `TPDMC_ROUTE_OFS: rdWord[14:0] = routeReg;
      `TPDMC_DIR_OFS:   rdWord[5:0]  = pinDir;
      `TPDMC_PSRC_OFS:  rdWord[17:0] = pinSrc;
      `TPDMC_CSRC_OFS:  rdWord[8:0]  = chanSrc;
      `TPDMC_PULL_OFS:  rdWord[13:0] = {pullDownReg, 2'h0, pullUpReg};
      `TPDMC_MON_OFS:   rdWord[5:0]  = monEn;
      `TPDMC_EVENT_OFS: rdWord[5:0]  = eventFlag;
      `TPDMC_STAT_OFS:  rdWord[8:0]  = {flipSync, 2'h0, portSync};
      default:          rdHit = 1'b0;
    endcase
  end

  // Bus handshakes, register writes and event flags
  always @(posedge mclk) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TPDMC_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `TPDMC_RESP_OKAY;
      wrAddr        <= 8'h00;
      wrData        <= 32'h0;
      wrStrb        <= 4'h0;
      routeReg      <= `TPDMC_ROUTE_RST;
      pinDir        <= `TPDMC_DIR_RST;
      pinSrc        <= `TPDMC_PSRC_RST;
      chanSrc       <= `TPDMC_CSRC_RST;
      pullUpReg     <= 6'h00;
      pullDownReg   <= 6'h00;
      monEn         <= 6'h00;
      eventFlag     <= 6'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wrAddr        <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wrData       <= s_axi_wdata;
        wrStrb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      // Edge events, set wins over clear
      eventFlag <= eventFlag | edgeSeen;
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? `TPDMC_RESP_OKAY : `TPDMC_RESP_SLV;
        case (wrAddr)
          `TPDMC_ROUTE_OFS:
            routeReg <= routeMerge[14:0];
          `TPDMC_DIR_OFS:
            pinDir <= dirMerge[5:0];
          `TPDMC_PSRC_OFS:
            pinSrc <= psrcMerge[17:0];
          `TPDMC_CSRC_OFS:
            chanSrc <= csrcMerge[8:0];
          `TPDMC_PULL_OFS: begin
            if (wrStrb[0]) pullUpReg <= wrData[5:0];
            if (wrStrb[1]) pullDownReg <= wrData[13:8];
          end
          `TPDMC_MON_OFS:
            if (wrStrb[0]) monEn <= wrData[5:0];
          `TPDMC_EVENT_OFS:
            if (wrStrb[0]) eventFlag <= (eventFlag & ~wrData[5:0]) | edgeSeen;
          default: ;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdWord;
        s_axi_rresp   <= rdHit ? `TPDMC_RESP_OKAY : `TPDMC_RESP_SLV;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // tpdmc_port_mux
`default_nettype wire

// ===== tb/tpdmc_port_mux_monitor.sv
// Checker for the port mux control block.
// Assumes it is bound to tpdmc_port_mux, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module tpdmc_monitor (
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       cableFlipped,
  input wire logic       sbuSwap,
  input wire logic [2:0] topSwitchSel,
  input wire logic [2:0] bottomSwitchSel,
  input wire logic [2:0] sbuSwitchSel,
  input wire logic [5:0] portIn,
  input wire logic [5:0] portOe_b,
  input wire logic [5:0] compConnect,
  input wire logic       coreEvent,
  input wire logic [5:0] sysPinIn,
  input wire logic [5:0] sysPinOut,
  input wire logic [5:0] sysPinOe_b,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid
);
  logic [2:0] up;
  logic       touched;
  ////////////////////////////////////////////////////////////////////////////////
  // Cycles since reset, held at 7, and any write offered since
  always_ff @(posedge mclk) begin
    up <= !rst_b ? 3'h0 : up + {2'h0, up != 3'h7};
    touched <= !rst_b ? 1'h0 : touched | s_axi_awvalid;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  a_sbu_swap: assert property ((rst_b && $stable(cableFlipped))[*5] |-> sbuSwap == cableFlipped)
    else $error("sideband swap does not follow orientation");
  a_pair_swap: assert property ($changed(sbuSwap) |->
    {topSwitchSel, bottomSwitchSel} == {$past(bottomSwitchSel), $past(topSwitchSel)})
    else $error("top and bottom not exchanged");
  a_top_open_hiz: assert property ((topSwitchSel == 3'h0)[*2] |-> &portOe_b[1:0])
    else $error("unrouted top pins driven");
  a_sbu_open_hiz: assert property ((sbuSwitchSel == 3'h0)[*2] |-> &portOe_b[5:4])
    else $error("unrouted sideband pins driven");
  a_bypass_drive: assert property (up == 3'h2 && !touched |-> !sysPinOe_b[1])
    else $error("bypass output not driven");
  a_bypass_copy: assert property (up == 3'h7 && !touched |->
    sysPinOut[1] == $past(sysPinIn[0], 3))
    else $error("bypass copy wrong");
  a_event_raise: assert property (|((portIn ^ $past(portIn)) & compConnect) |-> ##[2:5] coreEvent)
    else $error("event not raised");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  c_flip: cover property ($rose(sbuSwap));
  c_event: cover property ($rose(coreEvent));
  c_read: cover property (s_axi_rvalid);
endmodule // tpdmc_monitor
bind tpdmc_port_mux tpdmc_monitor u_tpdmc_monitor (.*);
`default_nettype wire

// ===== tb/tpdmc_sys_model.sv
// System-side controllers on the UART, serial and general pins.
// Assumes the bench sets what each controller drives.
`timescale 1ns/1ps
`default_nettype none
module tpdmc_sys_model (
  input  wire logic [5:0] drive,
  input  wire logic [5:0] sysPinOut,
  input  wire logic [5:0] sysPinOe_b,
  output wire logic [5:0] sysPinIn
);
  // Pin shows the block while it drives, else the controller
  assign sysPinIn = (sysPinOut & ~sysPinOe_b) | (drive & sysPinOe_b);
endmodule // tpdmc_sys_model
`default_nettype wire

// ===== tb/tpdmc_port_mux_test.sv
// Self-checking bench for the port mux control block.
// Assumes the block, its checker and the system-side model.
`timescale 1ns/1ps
`default_nettype none
`include "tpdmc_defines.vh"
module tpdmc_port_mux_test;
  logic        mclk, rst_b, cableFlipped, coreEvent, sbuSwap, lsxAnalogPass;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [5:0]  portIn, portOut, portOe_b, sysPinIn, sysPinOut, sysPinOe_b, portDrv, sysDrv;
  logic [5:0]  pullUpEn, pullDownEn, compConnect;
  logic [2:0]  topSwitchSel, bottomSwitchSel, sbuSwitchSel;
  int          err_total, compares, cyc;
  tpdmc_port_mux u_tpdmc_port_mux (.*);
  tpdmc_sys_model u_tpdmc_sys_model (.drive(sysDrv), .*);
  // Port pins resolve block drive against the cable side
  assign portIn = (portOut & ~portOe_b) | (portDrv & portOe_b);
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  // Cut a hang short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_total++;
      finish_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %0t: got %h, want %h", $time, s, e);
    end
  endtask
  // One register access, write or read
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tr;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    do begin
      @(negedge mclk);
      ta = s_axi_awready & s_axi_awvalid | s_axi_arready & s_axi_arvalid;
      tw = s_axi_wready & s_axi_wvalid;
      tr = s_axi_bvalid & s_axi_bready | s_axi_rvalid & s_axi_rready;
      q = s_axi_rdata;
      rsp = w ? s_axi_bresp : s_axi_rresp;
      @(posedge mclk);
      if (ta) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tr) {s_axi_bready, s_axi_rready} <= 2'h0;
    end while (!tr);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task test_bypass;
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk);
      sysDrv <= {5'h00, i == 0};
      repeat (4) @(negedge mclk);
      chk(sysPinOe_b[1], 1'h0);
      chk(sysPinOut[1], i == 0);
    end
    $display("test_bypass done");
  endtask
  task test_regs;
    xfer(0, `TPDMC_DIR_OFS, 0);
    chk(q, 32'h2);
    xfer(0, `TPDMC_PSRC_OFS, 0);
    chk(q, 32'h18);
    xfer(1, `TPDMC_DIR_OFS, 32'h22);
    repeat (2) @(negedge mclk);
    chk({sysPinOe_b[5], sysPinOe_b[1]}, 2'h0);
    xfer(1, 8'h40, 32'hffff);
    chk(rsp, `TPDMC_RESP_SLV);
    xfer(0, 8'h40, 0);
    chk(rsp, `TPDMC_RESP_SLV);
    chk(q, 32'h0);
    xfer(1, `TPDMC_PULL_OFS, 32'h2a15);
    xfer(0, `TPDMC_PULL_OFS, 0);
    chk(q, 32'h2a15);
    chk({pullDownEn, pullUpEn}, 12'ha95);
    $display("test_regs done");
  endtask
  task test_route;
    chk(portOe_b, 6'h3f);
    xfer(1, `TPDMC_ROUTE_OFS, 32'h321);
    repeat (2) @(negedge mclk);
    chk({topSwitchSel, bottomSwitchSel, sbuSwitchSel, sbuSwap}, 10'h0a6);
    @(posedge mclk);
    cableFlipped <= 1'h1;
    repeat (6) @(negedge mclk);
    chk({topSwitchSel, bottomSwitchSel, sbuSwap}, 7'h23);
    xfer(1, `TPDMC_ROUTE_OFS, 32'h7);
    repeat (5) @(negedge mclk);
    chk(portOe_b[3:0], 4'hb);
    chk(portOut[2], sysPinIn[0]);
    @(posedge mclk);
    sysDrv <= 6'h10;
    xfer(1, `TPDMC_CSRC_OFS, 32'h4);
    repeat (4) @(negedge mclk);
    chk(portOut[2], 1'h1);
    xfer(1, `TPDMC_ROUTE_OFS, 32'h2007);
    repeat (3) @(negedge mclk);
    chk({portOe_b, sysPinOe_b[1:0]}, 8'hff);
    xfer(1, `TPDMC_ROUTE_OFS, 32'h1200);
    repeat (3) @(negedge mclk);
    chk({lsxAnalogPass, sbuSwitchSel, portOe_b}, 10'h2bf);
    @(posedge mclk);
    portDrv <= 6'h10;
    sysDrv <= 6'h08;
    xfer(1, `TPDMC_ROUTE_OFS, 32'h200);
    repeat (4) @(negedge mclk);
    chk({lsxAnalogPass, portOe_b, portOut[5]}, 8'h3f);
    chk({sysPinOe_b[3:2], sysPinOut[2]}, 3'h5);
    xfer(1, `TPDMC_ROUTE_OFS, 32'h4200);
    repeat (3) @(negedge mclk);
    chk({portOe_b, sysPinOe_b[3:2]}, 8'hff);
    xfer(1, `TPDMC_ROUTE_OFS, 32'h0);
    $display("test_route done");
  endtask
  task test_event;
    xfer(1, `TPDMC_MON_OFS, 32'h1);
    @(posedge mclk);
    portDrv <= 6'h01;
    repeat (6) @(negedge mclk);
    chk(coreEvent, 1'h1);
    chk(compConnect, 6'h01);
    xfer(1, `TPDMC_EVENT_OFS, 32'h1);
    @(posedge mclk);
    portDrv <= 6'h03;
    repeat (6) @(negedge mclk);
    chk(coreEvent, 1'h0);
    $display("test_event done");
  endtask
  task finish_test;
    $display("compares %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_b, cableFlipped, portDrv, sysDrv, s_axi_wstrb} = 18'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'h1;
    test_bypass;
    test_regs;
    test_route;
    test_event;
    finish_test;
  end
endmodule // tpdmc_port_mux_test
`default_nettype wire
